/* File: core/nvsp_ctrl.sv */
// Host-side controller driving the nonvolatile SRAM pins
`timescale 1ns/10ps
`default_nettype none
module nvsp_ctrl
  import nvsp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_store,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   store_done,
  output logic [ADDR_W-1:0]      addr_in,
  output logic                   chip_on_n,
  output logic                   load_data_n,
  output logic                   drive_out_n,
  input  wire logic [DATA_W-1:0] data_pins_i,
  output logic [DATA_W-1:0]      data_pins_o,
  output logic                   data_pins_oe,
  input  wire logic              nv_save_busy_n_i,
  output logic                   nv_save_busy_n_o,
  output logic                   nv_save_busy_n_oe
);
  nvsp_tmr_if tif ();
  nvsp_timer u_timer (
    .clock (clock),
    .rst   (rst),
    .tif   (tif)
  );

  nvsp_state_t       st_reg,     st_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0] wdat_reg,   wdat_next;
  logic [DATA_W-1:0] rdat_reg,   rdat_next;
  logic              ce_n_reg,   ce_n_next;
  logic              we_n_reg,   we_n_next;
  logic              oe_n_reg,   oe_n_next;
  logic              doe_reg,    doe_next;
  logic              hsb_oe_reg, hsb_oe_next;
  logic              rdy_reg,    rdy_next;
  logic              rv_reg,     rv_next;
  logic              sd_reg,     sd_next;
  logic              seen_reg,   seen_next;
  logic              boot_ld_reg, boot_ld_next;
  logic              tload;
  logic [CNT_W-1:0]  tval;

  assign tif.load  = tload;
  assign tif.value = tval;

  always_comb begin
    st_next     = st_reg;
    addr_next   = addr_reg;
    wdat_next   = wdat_reg;
    rdat_next   = rdat_reg;
    ce_n_next   = ce_n_reg;
    we_n_next   = we_n_reg;
    oe_n_next   = oe_n_reg;
    doe_next    = doe_reg;
    hsb_oe_next = hsb_oe_reg;
    rdy_next    = 1'b0;
    rv_next     = 1'b0;
    sd_next     = 1'b0;
    seen_next   = seen_reg;
    tload       = 1'b0;
    tval        = CNT_ZERO;
    case (st_reg)
      NVSP_BOOT: begin
        if (tif.done && !boot_ld_reg) begin
          st_next  = NVSP_IDLE;
          rdy_next = 1'b1;
        end
      end
      NVSP_IDLE: begin
        rdy_next = 1'b1;
        if (!nv_save_busy_n_i) begin
          rdy_next = 1'b0;
        end else if (req_valid && rdy_reg) begin
          rdy_next = 1'b0;
          addr_next = req_addr;
          wdat_next = req_wdata;
          if (req_store) begin
            hsb_oe_next = 1'b1;
            seen_next   = 1'b0;
            tload       = 1'b1;
            tval        = CNT_W'(CYC_STORE_PW);
            st_next     = NVSP_STREQ;
          end else if (req_write) begin
            we_n_next = 1'b0;
            st_next   = NVSP_WRITE;
            tload     = 1'b1;
            tval      = CNT_W'(CYC_ACCESS);
          end else begin
            oe_n_next = 1'b0;
            st_next   = NVSP_READ;
            tload     = 1'b1;
            tval      = CNT_W'(CYC_ACCESS);
          end
        end
      end
      NVSP_READ: begin
        ce_n_next = 1'b0;
        if (tif.done && !ce_n_reg) begin
          rdat_next = data_pins_i;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
          rv_next   = 1'b1;
          st_next   = NVSP_END;
        end
      end
      NVSP_WRITE: begin
        doe_next  = 1'b1;
        ce_n_next = 1'b0;
        if (tif.done && !ce_n_reg) begin
          ce_n_next = 1'b1;
          rv_next   = 1'b1;
          st_next   = NVSP_END;
        end
      end
      NVSP_STREQ: begin
        if (tif.done) begin
          hsb_oe_next = 1'b0;
          tload       = 1'b1;
          tval        = CNT_W'(CYC_BUSY);
          st_next     = NVSP_STBUSY;
        end
      end
      NVSP_STBUSY: begin
        if (!nv_save_busy_n_i) begin
          seen_next = 1'b1;
        end else if (seen_reg || tif.done) begin
          tload   = 1'b1;
          tval    = CNT_W'(CYC_RECOVER);
          st_next = NVSP_RECOV;
        end
      end
      NVSP_RECOV: begin
        if (tif.done && nv_save_busy_n_i) begin
          sd_next = 1'b1;
          st_next = NVSP_IDLE;
        end
      end
      NVSP_END: begin
        doe_next  = 1'b0;
        we_n_next = 1'b1;
        st_next   = NVSP_IDLE;
      end
      default: begin
        st_next = NVSP_IDLE;
      end
    endcase
    // hold off accesses for recall time
    if (boot_ld_reg) begin
      tload = 1'b1;
      tval  = CNT_W'(CYC_RESTORE);
    end
  end

  // Boot timer load on reset exit
  always_comb begin
    boot_ld_next = 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg      <= NVSP_BOOT;
      addr_reg    <= ADDR_RST;
      wdat_reg    <= DATA_RST;
      rdat_reg    <= DATA_RST;
      ce_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      doe_reg     <= 1'b0;
      hsb_oe_reg  <= 1'b0;
      rdy_reg     <= 1'b0;
      rv_reg      <= 1'b0;
      sd_reg      <= 1'b0;
      seen_reg    <= 1'b0;
      boot_ld_reg <= 1'b1;
    end else begin
      st_reg      <= st_next;
      addr_reg    <= addr_next;
      wdat_reg    <= wdat_next;
      rdat_reg    <= rdat_next;
      ce_n_reg    <= ce_n_next;
      we_n_reg    <= we_n_next;
      oe_n_reg    <= oe_n_next;
      doe_reg     <= doe_next;
      hsb_oe_reg  <= hsb_oe_next;
      rdy_reg     <= rdy_next;
      rv_reg      <= rv_next;
      sd_reg      <= sd_next;
      seen_reg    <= seen_next;
      boot_ld_reg <= boot_ld_next;
    end
  end

  assign addr_in           = addr_reg;
  assign chip_on_n         = ce_n_reg;
  assign load_data_n       = we_n_reg;
  assign drive_out_n       = oe_n_reg;
  assign data_pins_o       = wdat_reg;
  assign data_pins_oe      = doe_reg;
  assign nv_save_busy_n_o  = 1'b0;
  assign nv_save_busy_n_oe = hsb_oe_reg;
  assign req_ready         = rdy_reg;
  assign rsp_valid         = rv_reg;
  assign rsp_rdata         = rdat_reg;
  assign store_done        = sd_reg;
endmodule
`default_nettype wire

/* File: core/nvsp_pkg.sv */
// Package of constants and types for the nonvolatile SRAM port controller
package nvsp_pkg;
  localparam int unsigned ADDR_W         = 15;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  // Device access and cycle time, worst grade
  localparam int unsigned T_ACCESS_NS    = 45;
  localparam int unsigned T_CYCLE_NS     = 45;
  // Store busy may take this long to appear after request
  localparam int unsigned T_BUSY_NS      = 300;
  localparam int unsigned T_STORE_PW_NS  = 15;
  localparam int unsigned T_RECOVER_NS   = 700;
  // Power-up recall time, in microseconds
  localparam int unsigned T_RESTORE_US   = 550;
  localparam int unsigned CYC_ACCESS     = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_BUSY       = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_STORE_PW   = (T_STORE_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RECOVER    = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_RESTORE    = (T_RESTORE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 13'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 13'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    NVSP_BOOT   = 3'b000,
    NVSP_IDLE   = 3'b001,
    NVSP_READ   = 3'b010,
    NVSP_WRITE  = 3'b011,
    NVSP_STREQ  = 3'b100,
    NVSP_STBUSY = 3'b101,
    NVSP_RECOV  = 3'b110,
    NVSP_END    = 3'b111
  } nvsp_state_t;
endpackage

/* File: core/nvsp_tmr_if.sv */
// Interface between the sequencer and its cycle timer
`timescale 1ns/10ps
`default_nettype none
interface nvsp_tmr_if;
  import nvsp_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             done;
  modport ctrl (output load, output value, input done);
  modport tmr  (input load, input value, output done);
endinterface
`default_nettype wire

/* File: core/nvsp_timer.sv */
// Down-counting cycle timer for pin phase lengths
`timescale 1ns/10ps
`default_nettype none
module nvsp_timer
  import nvsp_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  nvsp_tmr_if.tmr   tif
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    if (tif.load) begin
      cnt_next = tif.value;
    end else if (cnt_reg != CNT_ZERO) begin
      cnt_next = cnt_reg - CNT_ONE;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Done from count only, so a load taken on done forms no loop
  assign tif.done = (cnt_reg == CNT_ZERO);
endmodule
`default_nettype wire

/* File: test/nvsp_dev_model.sv */
// Behavioural model of the nonvolatile memory device
`timescale 1ns/10ps
`default_nettype none
module nvsp_dev_model
  import nvsp_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              chip_on_n,
  input  wire logic              load_data_n,
  input  wire logic              drive_out_n,
  input  wire logic [DATA_W-1:0] bus,
  input  wire logic              busy_pin,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe,
  output var logic               busy_low
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [ADDR_W-1:0] a_reg;
  logic              dirty = 1'b0;
  logic              w_first = 1'b0;
  logic              nv_busy = 1'b0;
  int                store_ns = 400;
  int                n_store = 0;
  initial begin
    busy_low = 1'b0;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  end
  always @(negedge chip_on_n) begin
    a_reg = addr_in;
    w_first = !load_data_n;
  end
  always @(posedge chip_on_n or posedge load_data_n) begin
    if (!(chip_on_n && load_data_n) && !nv_busy && busy_pin) begin
      mem[a_reg] = bus;
      dirty = 1'b1;
    end
  end
  assign dq_oe = !chip_on_n && !drive_out_n && load_data_n && !w_first && !nv_busy;
  assign dq_o = mem[addr_in];
  // supply loss store, no host command
  task automatic power_loss;
    nv_busy = 1'b1;
    busy_low = 1'b1;
    #150;
    if (dirty) begin
      #(store_ns);
      n_store++;
      dirty = 1'b0;
    end
    busy_low = 1'b0;
    nv_busy = 1'b0;
  endtask
  always @(negedge busy_pin) begin
    if (!nv_busy) begin
      nv_busy = 1'b1;
      #150;
      if (dirty) begin
        busy_low = 1'b1;
        #(store_ns);
        n_store++;
        dirty = 1'b0;
        busy_low = 1'b0;
      end
      wait (busy_pin);
      nv_busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/nvsp_checker.sv */
// Pin and handshake assertions for the port controller
`timescale 1ns/10ps
`default_nettype none
module nvsp_checker
  import nvsp_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              req_valid,
  input wire logic              req_store,
  input wire logic              req_ready,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic              chip_on_n,
  input wire logic              load_data_n,
  input wire logic              drive_out_n,
  input wire logic [DATA_W-1:0] data_pins_o,
  input wire logic              data_pins_oe,
  input wire logic              nv_save_busy_n_i,
  input wire logic              nv_save_busy_n_o,
  input wire logic              nv_save_busy_n_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_rd; !drive_out_n |-> load_data_n && !nv_save_busy_n_oe; endproperty
  a_rd: assert property (p_rd) else $error("strobe in read");
  property p_wr; !load_data_n |-> !nv_save_busy_n_oe; endproperty
  a_wr: assert property (p_wr) else $error("store in write");
  property p_drv; data_pins_oe |-> drive_out_n; endproperty
  a_drv: assert property (p_drv) else $error("bus clash");
  property p_od;
    $rose(nv_save_busy_n_oe) |-> !nv_save_busy_n_o ##1 (nv_save_busy_n_oe && !nv_save_busy_n_o) ##1 !nv_save_busy_n_oe;
  endproperty
  a_od: assert property (p_od) else $error("store pulse");
  property p_adr; !$stable(addr_in) |-> chip_on_n || load_data_n; endproperty
  a_adr: assert property (p_adr) else $error("address moved");
  property p_dat; !chip_on_n && !load_data_n |-> data_pins_oe ##1 (chip_on_n || $stable(data_pins_o)); endproperty
  a_dat: assert property (p_dat) else $error("write data");
  property p_sel; req_valid && req_ready && !req_store |-> ##[1:3] !chip_on_n; endproperty
  a_sel: assert property (p_sel) else $error("no select");
  property p_bsy; !nv_save_busy_n_i ##1 !nv_save_busy_n_i |-> !req_ready; endproperty
  a_bsy: assert property (p_bsy) else $error("ready while busy");
  c_rd: cover property (!drive_out_n && !chip_on_n);
  c_wr: cover property (!load_data_n && !chip_on_n);
  c_st: cover property (nv_save_busy_n_oe ##[1:3] !nv_save_busy_n_i [*3]);
endmodule
bind nvsp_ctrl nvsp_checker u_chk (.clock, .rst, .req_valid, .req_store, .req_ready, .addr_in,
  .chip_on_n, .load_data_n, .drive_out_n, .data_pins_o, .data_pins_oe, .nv_save_busy_n_i,
  .nv_save_busy_n_o, .nv_save_busy_n_oe);
`default_nettype wire

/* File: test/nonvolatile_sram_port_tb_top.sv */
// Self-checking bench for the nonvolatile port controller
`timescale 1ns/10ps
`default_nettype none
module nonvolatile_sram_port_tb_top;
  import nvsp_pkg::*;
  logic              clock = 1'b0, rst = 1'b1, flt = 1'b0;
  logic              req_valid = 1'b0, req_write = 1'b0, req_store = 1'b0;
  logic [ADDR_W-1:0] req_addr = ADDR_RST, addr_in, a;
  logic [DATA_W-1:0] req_wdata = DATA_RST, rsp_rdata, d_o, m_o, bus;
  logic              req_ready, rsp_valid, store_done, chip_on_n, load_data_n, drive_out_n;
  logic              d_oe, m_oe, hsb_o, hsb_oe, busy_low, nv_save_busy_n;
  logic [DATA_W-1:0] shadow [2**ADDR_W];
  logic [31:0]       lfsr = 32'h1afa;
  int                n_fail = 0, total_checks = 0, s;
  always #50 clock = ~clock;
  always @(posedge clock) flt <= ~flt;
  assign nv_save_busy_n = !(hsb_oe && !hsb_o) && !busy_low;
  assign bus = d_oe ? d_o : m_oe ? m_o : {DATA_W{flt}};
  nvsp_ctrl u_dut (.clock, .rst, .req_valid, .req_write, .req_store, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .store_done, .addr_in, .chip_on_n, .load_data_n,
    .drive_out_n, .data_pins_i(bus), .data_pins_o(d_o), .data_pins_oe(d_oe),
    .nv_save_busy_n_i(nv_save_busy_n), .nv_save_busy_n_o(hsb_o), .nv_save_busy_n_oe(hsb_oe));
  nvsp_dev_model u_dev (.addr_in, .chip_on_n, .load_data_n, .drive_out_n, .bus,
    .busy_pin(nv_save_busy_n), .dq_o(m_o), .dq_oe(m_oe), .busy_low);
  function automatic logic [31:0] next_rand(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic print_verdict;
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  task automatic do_req(logic st, logic wr, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req_valid <= 1'b1;
    req_store <= st;
    req_write <= wr;
    req_addr <= ad;
    req_wdata <= d;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 400);
    if (req_ready !== 1'b1) n = 800;
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (rsp_valid !== 1'b1 && store_done !== 1'b1 && n < 800);
    if (wr && !st) shadow[ad] = d;
    if (n >= 800) begin
      check("handshake", 8'h01, 8'h00);
      print_verdict();
    end
  endtask
  task automatic rd_chk(logic [ADDR_W-1:0] ad);
    do_req(1'b0, 1'b0, ad, DATA_RST);
    check("read data", shadow[ad], rsp_rdata);
  endtask
  task automatic st_chk(int exp);
    do_req(1'b1, 1'b0, ADDR_RST, DATA_RST);
    check("store count", 8'(exp), 8'(u_dev.n_store));
  endtask
  task automatic boot_chk;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < CYC_RESTORE + 100);
    check("recall wait", 8'h01, {7'h00, n >= CYC_RESTORE && n < CYC_RESTORE + 100});
    if (req_ready !== 1'b1) print_verdict();
  endtask
  // one driver on the data bus
  always @(negedge clock) if (!rst) check("bus clash", 8'h00, {7'h00, d_oe && m_oe});
  initial begin
    foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5a;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    boot_chk();
    rd_chk(15'h0000);
    rd_chk(15'h7fff);
    st_chk(0);
    do_req(1'b0, 1'b1, 15'h7fff, 8'hff);
    do_req(1'b0, 1'b1, 15'h0000, 8'h00);
    rd_chk(15'h7fff);
    rd_chk(15'h0000);
    for (int i = 0; i < 40; i++) begin
      lfsr = next_rand(lfsr);
      a = lfsr[14:0];
      if (lfsr[20]) do_req(1'b0, 1'b1, a, lfsr[31:24]);
      rd_chk(lfsr[19] ? a : 15'(lfsr[31:17]));
    end
    st_chk(1);
    st_chk(1);
    u_dev.store_ns = 3000;
    do_req(1'b0, 1'b1, a, 8'h3c);
    st_chk(2);
    rd_chk(a);
    do_req(1'b0, 1'b1, a, 8'hc3);
    u_dev.power_loss();
    check("autostore count", 8'h03, 8'(u_dev.n_store));
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    boot_chk();
    rd_chk(a);
    print_verdict();
  end
endmodule
`default_nettype wire
